// ---- rtl/spi_front_end.v ----
// slave serial front end with hold, write protect and status register
`timescale 1ns/1ps
`include "spi_front_end_regs.vh"
module spi_front_end #(
  parameter WRITE_CYCLE = `WRITE_CYCLE_CLKS
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       sck,
  input  wire       cs_n,
  input  wire       si,
  input  wire       hold_n,
  input  wire       wp_n,
  output reg        so_o,
  output reg        so_oe,
  output reg        busy_o,
  output reg        write_latch_o,
  output reg  [1:0] block_protect_o,
  output reg        protect_pin_enable_bit_o,
  output reg        array_cmd_o,
  output reg        array_write_o
);

  // ----------------------------------------
  // phases
  // ----------------------------------------
  localparam PH_OPC  = 2'd0;
  localparam PH_DATA = 2'd1;
  localparam PH_DEAD = 2'd2;

  // valid op-code check with bit 3 masked
  function opc_ok;
    input [7:0] b;
    begin
      opc_ok = ((b & `OPC_HI_MASK) == 8'h00) &&
               ((b[2:0] & `OPC_LO_MASK) != 3'h0) &&
               ((b[2:0] & `OPC_LO_MASK) != 3'h7);
    end
  endfunction

  // ----------------------------------------
  // input synchronisers, three stages
  // ----------------------------------------
  reg [2:0] sck_sy_ff;
  reg [2:0] cs_sy_ff;
  reg [2:0] si_sy_ff;
  reg [2:0] hold_sy_ff;
  reg [2:0] wp_sy_ff;
  reg       sck_ff;
  reg       cs_ff;
  reg       hold_ff;
  reg       wp_ff;

  // a change on sck, select, hold or write protect is taken once stages two and three agree; si is used from stage three as is
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_sy_ff  <= 3'h0;
      cs_sy_ff   <= 3'h7;
      si_sy_ff   <= 3'h0;
      hold_sy_ff <= 3'h7;
      wp_sy_ff   <= 3'h7;
      sck_ff     <= 1'b0;
      cs_ff      <= 1'b1;
      hold_ff    <= 1'b1;
      wp_ff      <= 1'b1;
    end else begin
      sck_sy_ff  <= {sck_sy_ff[1:0], sck};
      cs_sy_ff   <= {cs_sy_ff[1:0], cs_n};
      si_sy_ff   <= {si_sy_ff[1:0], si};
      hold_sy_ff <= {hold_sy_ff[1:0], hold_n};
      wp_sy_ff   <= {wp_sy_ff[1:0], wp_n};
      if (sck_sy_ff[1] == sck_sy_ff[2])
        sck_ff <= sck_sy_ff[2];
      if (cs_sy_ff[1] == cs_sy_ff[2])
        cs_ff <= cs_sy_ff[2];
      if (hold_sy_ff[1] == hold_sy_ff[2])
        hold_ff <= hold_sy_ff[2];
      if (wp_sy_ff[1] == wp_sy_ff[2])
        wp_ff <= wp_sy_ff[2];
    end
  end

  // sck stages agree at the rising edge, so data on stage three is settled
  wire sck_rise = sck_sy_ff[1] & sck_sy_ff[2] & ~sck_ff;
  wire sck_fall = ~sck_sy_ff[1] & ~sck_sy_ff[2] & sck_ff;
  wire si_s     = si_sy_ff[2];
  wire sel      = ~cs_ff;

  // ----------------------------------------
  // serial sequence state
  // ----------------------------------------
  reg [1:0] phase_ff;
  reg [2:0] bit_cnt_ff;
  reg [7:0] shin_ff;
  reg [7:0] shout_ff;
  reg [2:0] opc_ff;
  reg       paused_ff;
  reg       wr_pend_ff;
  reg [7:0] wr_data_ff;
  reg       wp_abort_ff;
  reg [7:0] status_ff;
  reg [22:0] cyc_cnt_ff;

  wire hw_protect = protect_pin_enable_bit_o & ~wp_ff;
  wire [7:0] status_rd = busy_o ? `ST_BUSY_VALUE : status_ff;
  wire [7:0] byte_in = {shin_ff[6:0], si_s};
  // hold only acts within an active selected sequence
  wire run = sel & ~paused_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff    <= PH_OPC;
      bit_cnt_ff  <= 3'h0;
      shin_ff     <= 8'h00;
      shout_ff    <= 8'h00;
      opc_ff      <= 3'h0;
      paused_ff   <= 1'b0;
      wr_pend_ff  <= 1'b0;
      wr_data_ff  <= 8'h00;
      wp_abort_ff <= 1'b0;
      status_ff   <= 8'h00;
      cyc_cnt_ff  <= 23'h0;
      busy_o      <= 1'b0;
      write_latch_o <= 1'b0;
      block_protect_o <= 2'h0;
      protect_pin_enable_bit_o <= 1'b0;
      so_o        <= 1'b0;
      so_oe       <= 1'b0;
      array_cmd_o <= 1'b0;
      array_write_o <= 1'b0;
    end else begin
      // self-timed programming cycle; pin no longer matters once started
      if (busy_o) begin
        if (cyc_cnt_ff == 23'h0) begin
          busy_o <= 1'b0;
          write_latch_o <= 1'b0;
          // latch drops with the cycle, so the stored copy must follow
          status_ff[`ST_WEN_BIT] <= 1'b0;
        end else
          cyc_cnt_ff <= cyc_cnt_ff - 23'h1;
      end
      if (!sel) begin
        // deselect restarts; pending status write launches here
        phase_ff   <= PH_OPC;
        bit_cnt_ff <= 3'h0;
        paused_ff  <= 1'b0;
        so_oe      <= 1'b0;
        array_cmd_o <= 1'b0;
        array_write_o <= 1'b0;
        if (wr_pend_ff) begin
          wr_pend_ff <= 1'b0;
          if (!wp_abort_ff && !hw_protect && !busy_o) begin
            protect_pin_enable_bit_o <= wr_data_ff[`ST_PPEN_BIT];
            block_protect_o <= {wr_data_ff[`ST_BP1_BIT], wr_data_ff[`ST_BP0_BIT]};
            status_ff <= {wr_data_ff[`ST_PPEN_BIT], 3'h0, wr_data_ff[`ST_BP1_BIT],
                          wr_data_ff[`ST_BP0_BIT], 1'b1, 1'b0};
            busy_o <= 1'b1;
            cyc_cnt_ff <= WRITE_CYCLE[22:0] - 23'h1;
          end
        end
        wp_abort_ff <= 1'b0;
      end else begin
        // pause entered and left only with clock low
        if (!sck_ff && phase_ff != PH_DEAD)
          paused_ff <= ~hold_ff;
        if (paused_ff)
          so_oe <= 1'b0;
        else if (phase_ff == PH_DATA && opc_ff == `OPC_RD_STATUS)
          so_oe <= 1'b1;
        // protect pin falling during a pending status write aborts it when the pin enable bit is set
        if (wr_pend_ff && hw_protect)
          wp_abort_ff <= 1'b1;
        if (run && sck_rise && phase_ff != PH_DEAD) begin
          shin_ff    <= byte_in;
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          if (bit_cnt_ff == 3'h7) begin
            if (phase_ff == PH_OPC) begin
              if (!opc_ok(byte_in))
                phase_ff <= PH_DEAD;
              else begin
                phase_ff <= PH_DATA;
                opc_ff <= byte_in[2:0];
                case (byte_in[2:0])
                  `OPC_SET_LATCH: if (!busy_o) begin
                    write_latch_o <= 1'b1;
                    status_ff[`ST_WEN_BIT] <= 1'b1;
                  end
                  `OPC_CLR_LATCH: if (!busy_o) begin
                    write_latch_o <= 1'b0;
                    status_ff[`ST_WEN_BIT] <= 1'b0;
                  end
                  `OPC_RD_STATUS: shout_ff <= status_rd;
                  `OPC_RD_ARRAY: array_cmd_o <= 1'b1;
                  `OPC_WR_ARRAY: begin
                    array_cmd_o <= 1'b1;
                    // no array write while the cell cycle runs
                    array_write_o <= write_latch_o & ~busy_o;
                  end
                  default: ;
                endcase
              end
            end else if (opc_ff == `OPC_WR_STATUS && write_latch_o && !busy_o) begin
              wr_data_ff <= byte_in;
              wr_pend_ff <= ~hw_protect;
            end else if (opc_ff == `OPC_RD_STATUS)
              shout_ff <= status_rd;
          end
        end
        if (run && sck_fall && phase_ff == PH_DATA && opc_ff == `OPC_RD_STATUS) begin
          so_o     <= shout_ff[7];
          shout_ff <= {shout_ff[6:0], 1'b0};
        end
      end
    end
  end

endmodule

// ---- rtl/spi_front_end_regs.vh ----
// constants for the serial memory front end
`ifndef SPI_FRONT_END_REGS_VH
`define SPI_FRONT_END_REGS_VH
// op-code bits [7:4] must be zero, bit 3 is don't-care
`define OPC_HI_MASK      8'hf0
`define OPC_LO_MASK      8'h07
`define OPC_SET_LATCH    3'h6
`define OPC_CLR_LATCH    3'h4
`define OPC_RD_STATUS    3'h5
`define OPC_WR_STATUS    3'h1
`define OPC_RD_ARRAY     3'h3
`define OPC_WR_ARRAY     3'h2
// status field positions
`define ST_BUSY_BIT      0
`define ST_WEN_BIT       1
`define ST_BP0_BIT       2
`define ST_BP1_BIT       3
`define ST_PPEN_BIT      7
`define ST_BUSY_VALUE    8'hff
// write cycle time in microseconds and in 100 ns clocks
`define WRITE_CYCLE_US   5000
`define CLK_PERIOD_NS    100
`define WRITE_CYCLE_CLKS ((`WRITE_CYCLE_US * 1000) / `CLK_PERIOD_NS)
`endif

// ---- test/spi_front_end_asserts.sv ----
// checker for the serial memory front end ports
`timescale 1ns/1ps
module spi_front_end_asserts #(
  parameter int WRITE_CYCLE = 200
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic       si,
  input wire logic       hold_n,
  input wire logic       wp_n,
  input wire logic       so_o,
  input wire logic       so_oe,
  input wire logic       busy_o,
  input wire logic       write_latch_o,
  input wire logic [1:0] block_protect_o,
  input wire logic       protect_pin_enable_bit_o,
  input wire logic       array_cmd_o,
  input wire logic       array_write_o
);
  localparam int LO = WRITE_CYCLE - 2;
  localparam int HI = WRITE_CYCLE + 6;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_OE_DESEL: assert property (cs_n [*6] |-> !so_oe)
    else $error("output enabled while deselected");
  AST_OE_HOLD: assert property (!hold_n [*8] |-> !so_oe)
    else $error("output enabled during pause");
  AST_BUSY_MIN: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("write cycle cut short");
  AST_BUSY_LEN: assert property ($rose(busy_o) |-> ##[LO:HI] !busy_o)
    else $error("write cycle length wrong");
  AST_BUSY_ONES: assert property ((busy_o && so_oe) [*8] |-> so_o)
    else $error("status not all ones while busy");
  AST_WP_BLOCK: assert property ((!wp_n && protect_pin_enable_bit_o) [*6] |-> !$rose(busy_o))
    else $error("status write started while protected");
  AST_REG_LOAD: assert property (!$rose(busy_o) |-> $stable(block_protect_o) && $stable(protect_pin_enable_bit_o))
    else $error("status bits changed without a write cycle");
  AST_ARRAY_WR: assert property (array_write_o |-> array_cmd_o && write_latch_o)
    else $error("array write without latch");
endmodule
bind spi_front_end spi_front_end_asserts #(.WRITE_CYCLE(WRITE_CYCLE)) u_chk (.*);

// ---- test/spi_front_end_tb.sv ----
// self-checking bench for the serial memory front end
`timescale 1ns/1ps
module spi_front_end_tb;
  logic clk = 0, rst_n = 0, wp_n = 1;
  wire sck, cs_n, si, hold_n, so_o, so_oe, busy_o, wl, ppen, acmd, awr;
  wire [1:0] bp;
  logic [7:0] rd;
  int n_mismatch = 0, samples_checked = 0;
  initial forever #50 clk = ~clk;
  spi_master_model m (.clk(clk), .so_o(so_o), .so_oe(so_oe), .sck(sck), .cs_n(cs_n),
    .si(si), .hold_n(hold_n));
  spi_front_end #(.WRITE_CYCLE(200)) DUT (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
    .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .busy_o(busy_o),
    .write_latch_o(wl), .block_protect_o(bp), .protect_pin_enable_bit_o(ppen),
    .array_cmd_o(acmd), .array_write_o(awr));
  task finish_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wait_busy(input logic v);
    int k;
    for (k = 0; k < 400 && busy_o !== v; k++) @(posedge clk);
    if (k == 400) begin n_mismatch++; finish_test(); end
  endtask
  task wsr(input [7:0] d, input int keep);
    m.frame(8'h0e, 8'h00, 0, -1, 0, rd);
    chk(wl, 8'h01);
    m.frame(8'h01, d, 1, -1, keep, rd);
  endtask
  task t_status();
    wsr(8'h8c, 0);
    wait_busy(1);
    m.frame(8'h05, 8'h00, 1, -1, 0, rd);
    chk(rd, 8'hff);
    wait_busy(0);
    m.frame(8'h0d, 8'h00, 1, -1, 0, rd);
    chk(rd, 8'h8c);
  endtask
  task t_wp();
    wp_n <= 0;
    wsr(8'h00, 0);
    chk(busy_o, 8'h00);
    wp_n <= 1;
    wsr(8'h00, 1);
    wp_n <= 0;
    // pin falls with select still low, then the frame ends
    m.tick(12);
    m.stop();
    chk({busy_o, bp}, 8'h03);
    wp_n <= 1;
    wsr(8'h00, 0);
    wp_n <= 0;
    wait_busy(0);
    chk({ppen, bp}, 8'h00);
    wsr(8'h04, 0);
    wait_busy(0);
    chk(bp, 8'h01);
    wp_n <= 1;
  endtask
  task t_bad();
    for (int i = 0; i < 3; i++) begin
      m.frame(i == 0 ? 8'h46 : (i == 1 ? 8'h07 : 8'h00), 8'h06, 1, -1, 0, rd);
      chk(rd, 8'hzz);
      chk(wl, 8'h00);
    end
  endtask
  task t_hold();
    m.frame(8'h06, 8'h00, 0, 3, 0, rd);
    chk(wl, 8'h01);
    m.frame(8'h05, 8'h00, 1, 5, 0, rd);
    chk(rd, 8'h06);
    m.frame(8'h02, 8'h00, 0, -1, 1, rd);
    chk(awr, 8'h01);
    m.stop();
    m.frame(8'h04, 8'h00, 0, -1, 0, rd);
    chk(wl, 8'h00);
    m.frame(8'h0b, 8'h00, 0, -1, 1, rd);
    chk({acmd, awr}, 8'h02);
    m.stop();
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    repeat (8) @(posedge clk);
    t_status();
    t_wp();
    t_bad();
    t_hold();
    finish_test();
  end
endmodule

// ---- test/spi_master_model.sv ----
// spi master model driving select, clock, data and hold
`timescale 1ns/1ps
module spi_master_model (
  input  wire clk,
  input  wire so_o,
  input  wire so_oe,
  output reg  sck,
  output reg  cs_n,
  output reg  si,
  output reg  hold_n
);
  initial begin
    sck = 0; cs_n = 1; si = 0; hold_n = 1;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // p picks the bit before which a pause is taken, -1 for none
  task bytex(input [7:0] tx, input int p, output [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      if (i == p) begin
        hold_n <= 1'b0;
        repeat (2) begin tick(4); sck <= 1'b1; tick(4); sck <= 1'b0; end
        tick(4);
        hold_n <= 1'b1;
      end
      tick(4); sck <= 1'b1; tick(4);
      rx[i] = so_oe ? so_o : 1'bz;
      sck <= 1'b0;
    end
  endtask
  // released data line shows the inverse of its last level
  task stop();
    cs_n <= 1'b1; si <= ~si; tick(10);
  endtask
  task frame(input [7:0] op, dat, input int nb, p, keep, output [7:0] rd);
    cs_n <= 1'b0; tick(4);
    bytex(op, p, rd);
    if (nb > 0) bytex(dat, p, rd);
    tick(4);
    if (keep == 0) stop();
  endtask
endmodule
